// ### mdu_pkg.sv
// package of register map and timing constants for the multiply/divide unit
package mdu_pkg;
   // ********************
   // register offsets
   // ********************
   localparam logic [7:0] ACC_BYTE0_IDX = 8'he9;
   localparam logic [7:0] ACC_BYTE1_IDX = 8'hea;
   localparam logic [7:0] ACC_BYTE2_IDX = 8'heb;
   localparam logic [7:0] ACC_BYTE3_IDX = 8'hec;
   localparam logic [7:0] OPND_LOW_IDX = 8'hed;
   localparam logic [7:0] OPND_HIGH_IDX = 8'hee;
   localparam logic [7:0] ARITH_CTRL_IDX = 8'hef;
   localparam int ADDR_W = 12;
   // ********************
   // field layout and resets
   // ********************
   localparam int START_BIT = 7;
   localparam int OPSEL_BIT = 6;
   localparam logic [31:0] ACC_RESET = 32'h0000_0000;
   localparam logic [15:0] OPND_RESET = 16'h0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   // ********************
   // timing
   // ********************
   localparam int SYS_CLK_HZ = 20000000;
   localparam int CALC_PERIODS = 16;
   localparam int CALC_CYCLES = CALC_PERIODS;
   localparam int CNT_W = $clog2(CALC_CYCLES + 1);
   typedef enum logic {OP_MUL, OP_DIV} op_sel_t;
endpackage

// ### mdu_core_if.sv
// interface joining the register front end to the arithmetic engine
`timescale 1ns/1ns
interface mdu_core_if;
   logic start;
   logic op_div;
   logic [31:0] acc_in;
   logic [15:0] opnd_in;
   logic done;
   logic [31:0] acc_out;
   logic [15:0] opnd_out;
   modport ctrl (output start, output op_div, output acc_in, output opnd_in,
      input done, input acc_out, input opnd_out);
   modport engine (input start, input op_div, input acc_in, input opnd_in,
      output done, output acc_out, output opnd_out);
endinterface

// ### mdu_engine.sv
// iterative 16x16 multiplier and 32/16 divider, one multiply step or two divide steps per clock
`timescale 1ns/1ns
module mdu_engine (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // arithmetic link
   mdu_core_if.engine core
);
   import mdu_pkg::*;

   logic [31:0] a_r;
   logic [31:0] a_nxt;
   logic [15:0] b_r;
   logic [16:0] rem_r;
   logic [16:0] rem_nxt;
   logic [32:0] prod_r;
   logic [32:0] prod_nxt;
   logic div_r;
   logic busy_r;
   logic [16:0] mul_sum;
   logic [31:0] a_nxt2;
   logic [CNT_W-1:0] cnt_r;
   logic [17:0] trial;
   logic [16:0] shifted;

   // ********************
   // one step of each operation
   // ********************
   // divide: restoring, two quotient bits shifted into a_r per step pair
   assign shifted = {rem_r[15:0], a_r[31]};
   assign trial = {1'b0, shifted} - {2'b00, b_r};
   assign rem_nxt = trial[17] ? shifted : trial[16:0];
   assign a_nxt = div_r ? {a_r[30:0], ~trial[17]} : a_r;
   // multiply: one multiplier bit per step, shift-add
   assign mul_sum = {1'b0, prod_r[31:16]} + {1'b0, a_r[15:0]};
   assign prod_nxt = prod_r[0] ? {1'b0, mul_sum, prod_r[15:1]} : {1'b0, prod_r[32:1]};

   // a 32-bit divide needs 32 steps; two steps per clock keeps 16 cycles
   logic [16:0] shifted2;
   logic [17:0] trial2;
   logic [16:0] rem_nxt2;
   assign shifted2 = {rem_nxt[15:0], a_r[30]};
   assign trial2 = {1'b0, shifted2} - {2'b00, b_r};
   assign rem_nxt2 = trial2[17] ? shifted2 : trial2[16:0];
   assign a_nxt2 = {a_nxt[30:0], ~trial2[17]};

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         a_r <= ACC_RESET;
         b_r <= OPND_RESET;
         rem_r <= 17'h0_0000;
         prod_r <= 33'h0_0000_0000;
         div_r <= 1'b0;
         busy_r <= 1'b0;
         cnt_r <= '0;
      end else begin
         if (core.start && !busy_r) begin
            a_r <= core.acc_in;
            b_r <= core.opnd_in;
            rem_r <= 17'h0_0000;
            prod_r <= {17'h0_0000, core.opnd_in};
            div_r <= core.op_div;
            busy_r <= 1'b1;
            cnt_r <= CNT_W'(CALC_CYCLES - 1);
         end else if (busy_r) begin
            if (div_r) begin
               a_r <= a_nxt2;
               rem_r <= rem_nxt2;
            end else begin
               prod_r <= prod_nxt;
            end
            if (cnt_r == '0) begin
               busy_r <= 1'b0;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end

   // ********************
   // results
   // ********************
   // zero divisor: quotient all ones, remainder wraps; no stall
   // done flags the last step; results are handed over with it
   assign core.done = busy_r && (cnt_r == '0);
   assign core.acc_out = div_r ? a_nxt2 : prod_nxt[31:0];
   assign core.opnd_out = div_r ? rem_nxt2[15:0] : b_r;
endmodule

// ### mdu_apb.sv
// multiply/divide unit with its byte registers on an APB slave
// Contract
// - 32-bit accumulator in four bytes, 16-bit operand in two, low byte lowest
// - select 0 multiplies accumulator low half by operand into full accumulator
// - select 1 divides 32-bit accumulator by 16-bit operand
// - division leaves quotient in accumulator, remainder in operand
// - writing 1 to control bit 7 starts; bit stays 1 until done
// - each operation completes within 16 clock periods
// - two operations: 16x16 multiply and 32/16 divide
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
module mdu_apb (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [mdu_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // status
   output logic o_busy
);
   import mdu_pkg::*;

   // ********************
   // state
   // ********************
   logic [31:0] acc_r;
   logic [15:0] opnd_r;
   logic start_r;
   logic opsel_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   mdu_core_if core ();

   // ********************
   // address decode
   // ********************
   wire setup = i_psel && !i_penable;
   wire access = i_psel && i_penable && pready_r;
   wire aligned = (i_paddr[1:0] == 2'b00);
   wire [ADDR_W-3:0] idx = i_paddr[ADDR_W-1:2];
   wire hit_a0 = aligned && (idx == (ADDR_W-2)'(ACC_BYTE0_IDX));
   wire hit_a1 = aligned && (idx == (ADDR_W-2)'(ACC_BYTE1_IDX));
   wire hit_a2 = aligned && (idx == (ADDR_W-2)'(ACC_BYTE2_IDX));
   wire hit_a3 = aligned && (idx == (ADDR_W-2)'(ACC_BYTE3_IDX));
   wire hit_bl = aligned && (idx == (ADDR_W-2)'(OPND_LOW_IDX));
   wire hit_bh = aligned && (idx == (ADDR_W-2)'(OPND_HIGH_IDX));
   wire hit_ct = aligned && (idx == (ADDR_W-2)'(ARITH_CTRL_IDX));
   wire hit_any = hit_a0 || hit_a1 || hit_a2 || hit_a3 || hit_bl || hit_bh || hit_ct;
   wire wr_ok = access && i_pwrite && hit_any && i_pstrb[0];
   wire [7:0] wb = i_pwdata[7:0];
   wire [7:0] ctrl_rd = {start_r, opsel_r, 6'h00};
   wire [7:0] rd_byte = hit_a0 ? acc_r[7:0] :
                        hit_a1 ? acc_r[15:8] :
                        hit_a2 ? acc_r[23:16] :
                        hit_a3 ? acc_r[31:24] :
                        hit_bl ? opnd_r[7:0] :
                        hit_bh ? opnd_r[15:8] :
                        hit_ct ? ctrl_rd : 8'h00;
   wire go = wr_ok && hit_ct && wb[START_BIT] && !start_r;
   wire ct_wr = wr_ok && hit_ct && !start_r;
   wire opsel_now = ct_wr ? wb[OPSEL_BIT] : opsel_r;

   // ********************
   // core hookup
   // ********************
   assign core.start = go;
   assign core.op_div = opsel_now;
   assign core.acc_in = acc_r;
   assign core.opnd_in = opnd_r;

   mdu_engine u_engine (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .core(core)
   );

   // ********************
   // apb answer, one wait-free access phase
   // ********************
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         prdata_r <= UNMAPPED_DATA;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup && !hit_any;
         prdata_r <= (setup && !i_pwrite) ? {24'h00_0000, rd_byte} : UNMAPPED_DATA;
      end
   end

   // ********************
   // data and control registers
   // ********************
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         acc_r <= ACC_RESET;
         opnd_r <= OPND_RESET;
         start_r <= 1'b0;
         opsel_r <= 1'b0;
      end else begin
         if (core.done) begin
            acc_r <= core.acc_out;
            opnd_r <= core.opnd_out;
            start_r <= 1'b0;
         end else if (go) begin
            start_r <= 1'b1;
         end
         // data writes during a run are ignored
         if (wr_ok && !start_r) begin
            if (hit_a0) acc_r[7:0] <= wb;
            if (hit_a1) acc_r[15:8] <= wb;
            if (hit_a2) acc_r[23:16] <= wb;
            if (hit_a3) acc_r[31:24] <= wb;
            if (hit_bl) opnd_r[7:0] <= wb;
            if (hit_bh) opnd_r[15:8] <= wb;
         end
         if (ct_wr) begin
            opsel_r <= wb[OPSEL_BIT];
         end
      end
   end

   assign o_prdata = prdata_r;
   assign o_pready = pready_r;
   assign o_pslverr = pslverr_r;
   assign o_busy = start_r;
endmodule

// ### mdu_apb_chk.sv
// assertion checker for the apb multiply/divide unit
`timescale 1ns/1ns
module mdu_apb_chk (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [mdu_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_busy
);
   import mdu_pkg::*;
   wire logic su = i_psel && !i_penable;
   wire logic [9:0] ix = i_paddr[11:2];
   wire logic hit = i_paddr[1:0] == 2'h0 && ix >= 10'(ACC_BYTE0_IDX) && ix <= 10'(ARITH_CTRL_IDX);
   wire logic ctl = i_paddr == {2'h0, ARITH_CTRL_IDX, 2'h0};
   wire logic acc_ph = i_psel && i_penable && o_pready;
   wire logic go = acc_ph && i_pwrite && ctl && i_pstrb[0] && i_pwdata[7];
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   chk_setup_answer: assert property (su |=> o_pready && o_pslverr == !$past(hit))
      else $error("bad answer");
   chk_ready_only: assert property (!su |=> !o_pready)
      else $error("stray ready");
   chk_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
      else $error("upper bits");
   chk_miss_zero: assert property (su && !hit |=> o_prdata == 32'h0)
      else $error("unmapped data");
   chk_start_busy: assert property (go && !o_busy |=> o_busy)
      else $error("no start");
   chk_busy_cause: assert property ($rose(o_busy) |-> $past(go))
      else $error("busy uncaused");
   chk_busy_len: assert property ($rose(o_busy) |-> ##16 $fell(o_busy))
      else $error("busy length");
   chk_busy_read: assert property (su && !i_pwrite && ctl |=> o_prdata[7] == $past(o_busy))
      else $error("busy readback");
endmodule
bind mdu_apb mdu_apb_chk mdu_apb_chk_i (.*);

// ### mdu_host.sv
// apb master model of the processor core
`timescale 1ns/1ns
module mdu_host (
   input wire logic i_sys_clk,
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [mdu_pkg::ADDR_W-1:0] o_paddr,
   output logic [31:0] o_pwdata,
   output logic [3:0] o_pstrb,
   input wire logic [31:0] i_prdata,
   input wire logic i_pready,
   input wire logic i_pslverr
);
   import mdu_pkg::*;
   initial {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata, o_pstrb} = '0;
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
      output logic [31:0] r, output logic e);
      @(posedge i_sys_clk);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= {24'h0, d};
      o_pstrb <= 4'h1;
      @(posedge i_sys_clk);
      o_penable <= 1'b1;
      do @(posedge i_sys_clk); while (i_pready !== 1'b1);
      r = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_pwdata <= ~o_pwdata;
   endtask
endmodule

// ### mdu_apb_tb.sv
// testbench for the apb multiply/divide unit
`timescale 1ns/1ns
module mdu_apb_tb;
   import mdu_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_busy, err;
   logic [ADDR_W-1:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd, a;
   logic [15:0] b;
   logic [3:0] i_pstrb;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   always #25 i_sys_clk = ~i_sys_clk;
   mdu_apb mdu_apb_i (.i_sys_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .o_busy);
   mdu_host mdu_host_i (.i_sys_clk, .o_psel(i_psel), .o_penable(i_penable),
      .o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata), .o_pstrb(i_pstrb),
      .i_prdata(o_prdata), .i_pready(o_pready), .i_pslverr(o_pslverr));
   task automatic conclude();
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic rw(input logic w, input logic [7:0] ix, input logic [7:0] d);
      mdu_host_i.xfer(w, {2'h0, ix, 2'h0}, d, rd, err);
   endtask
   task automatic run(input logic [31:0] x, input logic [15:0] y, input logic [7:0] c);
      for (int i = 0; i < 4; i++) rw(1'b1, ACC_BYTE0_IDX + 8'(i), x[8*i+:8]);
      rw(1'b1, OPND_LOW_IDX, y[7:0]);
      rw(1'b1, OPND_HIGH_IDX, y[15:8]);
      rw(1'b1, ARITH_CTRL_IDX, c);
      rw(1'b1, ARITH_CTRL_IDX, c ^ 8'h40);
      rw(1'b0, ARITH_CTRL_IDX, 8'h00);
      chk("ctrl busy", {24'h0, c}, rd);
      chk("busy pin", 32'h1, {31'h0, o_busy});
      for (int n = 0; n < 20 && rd[7] !== 1'b0; n++) rw(1'b0, ARITH_CTRL_IDX, 8'h00);
      chk("done", 32'h0, {24'h0, rd[7:0] & 8'h80});
      for (int i = 0; i < 4; i++) begin
         rw(1'b0, ACC_BYTE0_IDX + 8'(i), 8'h00);
         a[8*i+:8] = rd[7:0];
      end
      rw(1'b0, OPND_LOW_IDX, 8'h00);
      b[7:0] = rd[7:0];
      rw(1'b0, OPND_HIGH_IDX, 8'h00);
      b[15:8] = rd[7:0];
   endtask
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      repeat (16) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rw(1'b0, ACC_BYTE0_IDX + 8'(i), 8'h00);
         chk("reset value", 32'h0, rd);
      end
      rw(1'b0, 8'hf0, 8'h00);
      chk("unmapped", 32'h1, {31'h0, err});
      run(32'hdead_1234, 16'hbeef, 8'h80);
      chk("product", 32'h1234 * 32'hbeef, a);
      run(32'hfedc_ba98, 16'h1234, 8'hc0);
      chk("quotient", 32'hfedc_ba98 / 32'h1234, a);
      chk("remainder", 32'hfedc_ba98 % 32'h1234, {16'h0, b});
      run(32'h0001_0000, 16'h0000, 8'hc0);
      conclude();
   end
endmodule
